// ### rtl/rcss_cfg.svh
// Constants for the reset and clock start-up sequencer.
`ifndef RCSS_CFG_SVH
`define RCSS_CFG_SVH
// ============================================================
// Timing
`define RCSS_CLK_PERIOD_NS 25
`define RCSS_POR_DELAY_NS 10000
`define RCSS_MON_DELAY_US 100
`define RCSS_POR_CYCLES ((`RCSS_POR_DELAY_NS + `RCSS_CLK_PERIOD_NS - 1) / `RCSS_CLK_PERIOD_NS)
`define RCSS_MON_CYCLES ((`RCSS_MON_DELAY_US * 1000 + `RCSS_CLK_PERIOD_NS - 1) / `RCSS_CLK_PERIOD_NS)
`define RCSS_POWER_UP_TIMER_CYCLES 640000
`define RCSS_OST_CYCLES 1024
// ============================================================
// Timer slots
`define RCSS_NUM_TIMERS 3
`define RCSS_T_POR 0
`define RCSS_T_POWER_UP_TIMER 1
`define RCSS_T_OST 2
// ============================================================
// Register port and map (word indexes)
`define RCSS_ADDR_W 4
`define RCSS_DATA_W 16
`define RCSS_REG_TRIM 4'h0
`define RCSS_REG_OSC 4'h1
`define RCSS_REG_RESET_CONTROL_REG 4'h2
// ============================================================
// Register fields and reset values
`define RCSS_TRIM_W 4
`define RCSS_TRIM_RESET 4'h0
`define RCSS_OSC_SRC_MSB 1
`define RCSS_OSC_SRC_LSB 0
`define RCSS_OSC_PLL_BIT 2
`define RCSS_OSC_FAIL_BIT 3
`define RCSS_OSC_SWITCH_BIT 4
`define RCSS_OSC_LOCK_BIT 5
`define RCSS_OSC_SWBACK_BIT 7
`define RCSS_RESET_CONTROL_REG_POR_BIT 0
`define RCSS_RESET_CONTROL_REG_BOR_BIT 1
// ============================================================
// Configuration fields
`define RCSS_FAM_FAST_RC 3'h1
`define RCSS_FAM_LOW_PWR_RC 3'h2
`define RCSS_FAM_LOWPWR_XTAL 3'h3
`define RCSS_PM_BASE_MSB 4
`define RCSS_PM_BASE_LSB 2
`define RCSS_PM_MULT_MSB 1
`define RCSS_PM_MULT_LSB 0
`define RCSS_SECOND_OSC_PIN_DIV_W 2
`endif

// ### rtl/rcss_pkg.sv
// Types shared by the reset and clock start-up sequencer.
package rcss_pkg;
   typedef enum logic [1:0] {
      SRC_FAST_RC = 2'h0,
      SRC_LOW_PWR_RC = 2'h1,
      SRC_PRIMARY = 2'h2,
      SRC_LOWPWR_XTAL = 2'h3
   } rcss_src_t;
   typedef enum logic [2:0] {
      BASE_MED_XTAL = 3'h0,
      BASE_HI_XTAL = 3'h1,
      BASE_HI_DIV2 = 3'h2,
      BASE_HI_DIV3 = 3'h3,
      BASE_EXT_CLK = 3'h4,
      BASE_EXT_CLK_IO = 3'h5,
      BASE_EXT_RC = 3'h6,
      BASE_MISC = 3'h7
   } rcss_base_t;
   typedef enum logic [1:0] {
      MULT_NONE = 2'h0,
      MULT_X4 = 2'h1,
      MULT_X8 = 2'h2,
      MULT_X16 = 2'h3
   } rcss_mult_t;
   typedef enum logic [1:0] {
      PREDIV_NONE = 2'h0,
      PREDIV_DIV2 = 2'h1,
      PREDIV_DIV3 = 2'h2
   } rcss_prediv_t;
   typedef enum logic [1:0] {
      ST_HOLD = 2'b00,
      ST_WAIT = 2'b01,
      ST_RUN = 2'b10
   } rcss_state_t;
endpackage : rcss_pkg

// ### rtl/rcss_sync.sv
// Three-stage input synchroniser that accepts a change once stages two and three agree.
`timescale 1ns/100ps
module rcss_sync #(
   parameter int W = 3
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] s1_q;
   logic [W-1:0] s2_q;
   logic [W-1:0] s3_q;
   logic [W-1:0] q_d;
   logic [W-1:0] differ;

   // A disagreement between stages two and three keeps the old value.
   assign differ = s2_q ^ s3_q;
   assign q_d = (~differ & s2_q) | (differ & q);

   always_ff @(posedge clk) begin
      if (rst) begin
         s1_q <= '0;
         s2_q <= '0;
         s3_q <= '0;
         q <= '0;
      end else begin
         s1_q <= d;
         s2_q <= s1_q;
         s3_q <= s2_q;
         q <= q_d;
      end
   end
endmodule : rcss_sync

// ### rtl/rcss_top.sv
// Reset and clock start-up sequencer with clock-fail fallback and brown-out handling.
//
// Chosen here: the register addresses and strobed register access.
`timescale 1ns/100ps
`include "rcss_cfg.svh"

// Behaviour
// - Clock fault after timers raises clock-fail trap
// - Trap switches system clock to fast RC
// - Fault checked only after both reset timers
// - Power-up timer off, no crystal: fast exit
// - No clock, monitor off: core stays frozen
// - Brown-out resets the whole device
// - Brown-out picks source from configuration fields
// - Oscillator modes withhold clock until start-up timer
// - PLL use withholds clock until lock bit
// - Reset released after both delays elapse
// - Zero power-up delay with crystal: monitor delay
// - Brown-out sets status flag bit one
// - Brown-out detection active in Sleep, Idle
// - PLL multiplies by four, eight, sixteen
// - High-speed crystal prescaled by two or three
// - Second pin: quarter clock, or general I/O
// - Fast RC and low-power RC selectable
// - Four-bit trim code tunes fast RC
module rcss_top
   import rcss_pkg::*;
#(
   parameter int unsigned POWER_UP_TIMER_CYCLES = `RCSS_POWER_UP_TIMER_CYCLES,
   parameter int unsigned OST_CYCLES = `RCSS_OST_CYCLES
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic brownout_det,
   input wire logic osc_running,
   input wire logic pll_lock,
   input wire logic [2:0] cfg_osc_family_select,
   input wire logic [4:0] cfg_primary_osc_mode_select,
   input wire logic cfg_clock_fail_monitor_en,
   input wire logic cfg_power_up_timer_en,
   input wire logic cfg_brownout_en,
   input wire logic [`RCSS_ADDR_W-1:0] reg_addr,
   input wire logic [`RCSS_DATA_W-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [`RCSS_DATA_W-1:0] reg_rdata,
   output logic core_rst,
   output logic core_clk_en,
   output logic [1:0] clk_src_sel,
   output logic pll_en,
   output logic [1:0] pll_mult,
   output logic [1:0] pll_prediv,
   output logic [`RCSS_TRIM_W-1:0] fast_rc_trim_code,
   output logic fast_rc_en,
   output logic low_pwr_rc_en,
   output logic clk_fail_trap,
   output logic second_osc_pin_o,
   output logic second_osc_pin_oe,
   output logic second_osc_pin_gpio
);
   localparam int NT = `RCSS_NUM_TIMERS;
   localparam logic [31:0] POR_LIM = 32'(`RCSS_POR_CYCLES);
   localparam logic [31:0] MON_LIM = 32'(`RCSS_MON_CYCLES);
   localparam logic [31:0] POWER_UP_TIMER_LIM = 32'(POWER_UP_TIMER_CYCLES);
   localparam logic [31:0] OST_LIM = 32'(OST_CYCLES);

   // ============================================================
   // Input synchronisation and reset sources
   logic bor_s;
   logic osc_run_s;
   logic lock_s;
   logic bor_hold;
   logic seq_rst;

   rcss_sync #(.W(3)) u_sync (
      .clk(clk),
      .rst(rst),
      .d({brownout_det, osc_running, pll_lock}),
      .q({bor_s, osc_run_s, lock_s})
   );

   // Detection has no gating by Sleep or Idle, so it trips in every power state.
   assign bor_hold = cfg_brownout_en & bor_s;
   assign seq_rst = rst | bor_hold;

   // ============================================================
   // Configuration latch and mode decode
   rcss_state_t state_q;
   rcss_state_t state_d;
   logic [2:0] fam_q;
   logic [4:0] pm_q;
   rcss_base_t base;
   rcss_mult_t mult;
   logic fam_primary;
   logic misc_pll;
   logic low_freq_xtal;
   logic illegal;
   rcss_src_t cfg_src;
   logic cfg_xtal;
   logic cfg_pll;
   logic cfg_ext;

   // Fields are captured while the sequence is held, so any reset re-reads them.
   always_ff @(posedge clk) begin
      if (seq_rst || state_q == ST_HOLD) begin
         fam_q <= cfg_osc_family_select;
         pm_q <= cfg_primary_osc_mode_select;
      end
   end

   assign base = rcss_base_t'(pm_q[`RCSS_PM_BASE_MSB:`RCSS_PM_BASE_LSB]);
   assign mult = rcss_mult_t'(pm_q[`RCSS_PM_MULT_MSB:`RCSS_PM_MULT_LSB]);
   assign fam_primary = !(fam_q inside {`RCSS_FAM_FAST_RC, `RCSS_FAM_LOW_PWR_RC,
                                        `RCSS_FAM_LOWPWR_XTAL});
   assign misc_pll = fam_primary && base == BASE_MISC && mult != MULT_NONE;
   assign low_freq_xtal = fam_primary && base == BASE_MISC && mult == MULT_NONE;
   // Unused mode codes fall back to the fast RC so the part always gets a clock.
   assign illegal = fam_primary &&
      ((base == BASE_HI_XTAL && mult != MULT_NONE) ||
       (base inside {BASE_HI_DIV2, BASE_HI_DIV3} && mult == MULT_NONE) ||
       (base == BASE_EXT_CLK && mult != MULT_NONE) ||
       (base == BASE_EXT_RC && mult > MULT_X4));
   assign cfg_src = (fam_q == `RCSS_FAM_LOW_PWR_RC) ? SRC_LOW_PWR_RC :
                    (fam_q == `RCSS_FAM_LOWPWR_XTAL) ? SRC_LOWPWR_XTAL :
                    (!fam_primary || illegal || misc_pll) ? SRC_FAST_RC :
                    SRC_PRIMARY;
   assign cfg_xtal = (cfg_src == SRC_LOWPWR_XTAL) || low_freq_xtal ||
      (cfg_src == SRC_PRIMARY && base inside {BASE_MED_XTAL, BASE_HI_XTAL,
                                              BASE_HI_DIV2, BASE_HI_DIV3});
   assign cfg_pll = fam_primary && !illegal && mult != MULT_NONE;
   assign cfg_ext = (cfg_src == SRC_PRIMARY) || (cfg_src == SRC_LOWPWR_XTAL);

   // ============================================================
   // Clock-fail fallback state
   logic fail_q;
   logic fail_d;
   logic switch_q;
   logic switch_d;
   logic fail_set;
   logic fail_clr;
   logic swback_wr;
   logic tgt_ready;
   logic trap_q;
   rcss_src_t eff_src;
   logic [NT-1:0] tmr_done;

   // The configured source is ready once it runs, has settled and, with PLL, locked.
   assign tgt_ready = (!cfg_ext || osc_run_s) && tmr_done[`RCSS_T_OST] &&
                      (!cfg_pll || lock_s);
   assign fail_set = state_q == ST_RUN && cfg_clock_fail_monitor_en &&
                     !fail_q && !tgt_ready;
   assign fail_clr = switch_q && tgt_ready;
   assign fail_d = fail_set | (fail_q & ~fail_clr);
   assign switch_d = (switch_q | (swback_wr & fail_q)) & ~fail_clr;
   assign eff_src = fail_q ? SRC_FAST_RC : cfg_src;

   always_ff @(posedge clk) begin
      if (seq_rst) begin
         fail_q <= 1'b0;
         switch_q <= 1'b0;
         trap_q <= 1'b0;
      end else begin
         fail_q <= fail_d;
         switch_q <= switch_d;
         trap_q <= fail_set;
      end
   end

   // ============================================================
   // Delay timers: power-on, power-up or monitor, oscillator start-up
   logic [31:0] tmr_lim [NT];
   logic [NT-1:0] tmr_en;
   logic [NT-1:0] tmr_clr;

   assign tmr_lim[`RCSS_T_POR] = POR_LIM;
   // With both monitor and power-up timer off and no crystal this limit is zero.
   assign tmr_lim[`RCSS_T_POWER_UP_TIMER] = cfg_power_up_timer_en ? POWER_UP_TIMER_LIM :
                                  cfg_xtal ? MON_LIM : '0;
   assign tmr_lim[`RCSS_T_OST] = cfg_xtal ? OST_LIM : '0;
   assign tmr_en[`RCSS_T_POR] = state_q == ST_WAIT;
   assign tmr_en[`RCSS_T_POWER_UP_TIMER] = state_q == ST_WAIT;
   assign tmr_en[`RCSS_T_OST] = state_q != ST_HOLD && (!cfg_ext || osc_run_s);
   assign tmr_clr[`RCSS_T_POR] = state_q == ST_HOLD;
   assign tmr_clr[`RCSS_T_POWER_UP_TIMER] = state_q == ST_HOLD;
   assign tmr_clr[`RCSS_T_OST] = state_q == ST_HOLD || (swback_wr && fail_q);

   for (genvar i = 0; i < NT; i++) begin : g_tmr
      logic [31:0] cnt_q;
      assign tmr_done[i] = cnt_q >= tmr_lim[i];
      always_ff @(posedge clk) begin
         if (seq_rst || tmr_clr[i]) begin
            cnt_q <= '0;
         end else if (tmr_en[i] && !tmr_done[i]) begin
            cnt_q <= cnt_q + 32'h0000_0001;
         end
      end
   end

   // ============================================================
   // Sequence control
   always_comb begin
      state_d = state_q;
      unique case (state_q)
         ST_HOLD: begin
            state_d = ST_WAIT;
         end
         ST_WAIT: begin
            if (tmr_done[`RCSS_T_POR] && tmr_done[`RCSS_T_POWER_UP_TIMER]) begin
               state_d = ST_RUN;
            end
         end
         ST_RUN: begin
            state_d = ST_RUN;
         end
         default: begin
            state_d = ST_HOLD;
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (seq_rst) begin
         state_q <= ST_HOLD;
      end else begin
         state_q <= state_d;
      end
   end

   assign core_rst = state_q != ST_RUN;
   // Without the monitor a dead source leaves the core frozen at its reset vector.
   assign core_clk_en = fail_q || tgt_ready;

   // ============================================================
   // Clock selector outputs
   assign clk_src_sel = eff_src;
   // The PLL keeps running during a switch-back so it can lock before the handover.
   assign pll_en = cfg_pll && (!fail_q || switch_q);
   assign pll_mult = pll_en ? mult : MULT_NONE;
   assign pll_prediv = !pll_en ? PREDIV_NONE :
                       (base == BASE_HI_DIV2) ? PREDIV_DIV2 :
                       (base == BASE_HI_DIV3) ? PREDIV_DIV3 : PREDIV_NONE;
   assign fast_rc_en = eff_src == SRC_FAST_RC;
   assign low_pwr_rc_en = eff_src == SRC_LOW_PWR_RC;
   assign clk_fail_trap = trap_q;

   // ============================================================
   // Second oscillator pin
   logic [`RCSS_SECOND_OSC_PIN_DIV_W-1:0] div_q;
   logic erc_mode;

   assign erc_mode = cfg_src == SRC_PRIMARY && base == BASE_EXT_RC && mult == MULT_NONE;
   assign second_osc_pin_gpio = cfg_src == SRC_PRIMARY &&
      (base == BASE_EXT_CLK_IO || (base == BASE_EXT_RC && mult == MULT_X4));
   assign second_osc_pin_oe = erc_mode && !fail_q;
   assign second_osc_pin_o = div_q[`RCSS_SECOND_OSC_PIN_DIV_W-1];

   // The top bit of a two-bit counter toggles every two cycles: a quarter-rate clock.
   always_ff @(posedge clk) begin
      if (seq_rst) begin
         div_q <= '0;
      end else begin
         div_q <= div_q + `RCSS_SECOND_OSC_PIN_DIV_W'(1);
      end
   end

   // ============================================================
   // Register port
   logic [`RCSS_TRIM_W-1:0] trim_q;
   logic por_flag_q;
   logic bor_flag_q;
   logic wr_trim;
   logic wr_osc;
   logic wr_reset_control_reg;
   logic por_clr;
   logic bor_clr;
   logic [`RCSS_DATA_W-1:0] osc_rd;
   logic [`RCSS_DATA_W-1:0] reset_control_reg_rd;
   logic [`RCSS_DATA_W-1:0] rd_mux;

   assign wr_trim = reg_wr && reg_addr == `RCSS_REG_TRIM;
   assign wr_osc = reg_wr && reg_addr == `RCSS_REG_OSC;
   assign wr_reset_control_reg = reg_wr && reg_addr == `RCSS_REG_RESET_CONTROL_REG;
   assign swback_wr = wr_osc && reg_wdata[`RCSS_OSC_SWBACK_BIT];
   assign por_clr = wr_reset_control_reg && !reg_wdata[`RCSS_RESET_CONTROL_REG_POR_BIT];
   assign bor_clr = wr_reset_control_reg && !reg_wdata[`RCSS_RESET_CONTROL_REG_BOR_BIT];

   always_comb begin
      osc_rd = '0;
      osc_rd[`RCSS_OSC_SRC_MSB:`RCSS_OSC_SRC_LSB] = eff_src;
      osc_rd[`RCSS_OSC_PLL_BIT] = pll_en;
      osc_rd[`RCSS_OSC_FAIL_BIT] = fail_q;
      osc_rd[`RCSS_OSC_SWITCH_BIT] = switch_q;
      osc_rd[`RCSS_OSC_LOCK_BIT] = lock_s;
      reset_control_reg_rd = '0;
      reset_control_reg_rd[`RCSS_RESET_CONTROL_REG_POR_BIT] = por_flag_q;
      reset_control_reg_rd[`RCSS_RESET_CONTROL_REG_BOR_BIT] = bor_flag_q;
   end

   assign rd_mux = (reg_addr == `RCSS_REG_TRIM) ? `RCSS_DATA_W'(trim_q) :
                   (reg_addr == `RCSS_REG_OSC) ? osc_rd :
                   (reg_addr == `RCSS_REG_RESET_CONTROL_REG) ? reset_control_reg_rd : '0;

   // The trim code follows the whole-device reset, so a brown-out restores nominal.
   always_ff @(posedge clk) begin
      if (seq_rst) begin
         trim_q <= `RCSS_TRIM_RESET;
      end else if (wr_trim) begin
         trim_q <= reg_wdata[`RCSS_TRIM_W-1:0];
      end
   end
   assign fast_rc_trim_code = trim_q;

   // Reset flags survive the brown-out they report; a new event wins over a clear.
   always_ff @(posedge clk) begin
      por_flag_q <= rst | (por_flag_q & ~por_clr);
      if (rst) begin
         bor_flag_q <= 1'b0;
      end else begin
         bor_flag_q <= bor_hold | (bor_flag_q & ~bor_clr);
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         reg_rdata <= '0;
      end else begin
         reg_rdata <= reg_rd ? rd_mux : '0;
      end
   end

   // ============================================================
   // Checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   trap_raise_a: assert property (
      (fail_set && !bor_hold) |=> (clk_fail_trap && fail_q))
      else $error("clock fault did not raise the trap");
   fast_rc_fallback_a: assert property (
      clk_fail_trap |-> (clk_src_sel == SRC_FAST_RC && !pll_en && core_clk_en))
      else $error("trap without fast RC fallback");
   eval_after_timers_a: assert property (
      clk_fail_trap |-> $past(tmr_done[`RCSS_T_POR] && tmr_done[`RCSS_T_POWER_UP_TIMER]))
      else $error("trap raised before reset timers expired");
   ost_hold_a: assert property (
      (!fail_q && !tmr_done[`RCSS_T_OST]) |-> !core_clk_en)
      else $error("clock released before start-up timer");
   lock_hold_a: assert property (
      (!fail_q && cfg_pll && !lock_s) |-> !core_clk_en)
      else $error("clock released before PLL lock");
   lock_read_a: assert property (
      (reg_rd && reg_addr == `RCSS_REG_OSC) |=>
         reg_rdata[`RCSS_OSC_LOCK_BIT] == $past(lock_s))
      else $error("lock bit misread");
   reset_release_a: assert property (
      $fell(core_rst) |-> $past(tmr_done[`RCSS_T_POR] && tmr_done[`RCSS_T_POWER_UP_TIMER]))
      else $error("reset released before delays elapsed");
   bor_reset_a: assert property (
      bor_hold |=> (core_rst && fast_rc_trim_code == `RCSS_TRIM_RESET) [*2])
      else $error("brown-out did not reset the device");
   bor_flag_a: assert property (
      bor_hold |=> bor_flag_q)
      else $error("brown-out flag not set");
   trim_write_a: assert property (
      (wr_trim && !seq_rst) |=> fast_rc_trim_code == $past(reg_wdata[`RCSS_TRIM_W-1:0]))
      else $error("trim code not updated");
   second_osc_pin_quarter_a: assert property (
      ($rose(second_osc_pin_o) && second_osc_pin_oe && !seq_rst) |=>
         (second_osc_pin_o [*1] ##1 !second_osc_pin_o [*2]))
      else $error("second pin not a quarter-rate clock");
   second_osc_pin_io_a: assert property (
      second_osc_pin_gpio |-> !second_osc_pin_oe)
      else $error("second pin driven in I/O mode");
endmodule : rcss_top

// ### testbench/rcss_core_model.sv
// Behavioural processor core that advances only while out of reset and clocked.
`timescale 1ns/100ps
module rcss_core_model (
   input wire logic clk,
   input wire logic core_rst,
   input wire logic core_clk_en,
   output logic [31:0] run_cnt
);
   // ============================================================
   // Execution counter
   // A core that is held in reset sits at its reset vector; one starved of clock holds its count.
   always_ff @(posedge clk) begin
      if (core_rst) begin
         run_cnt <= 32'h0000_0000;
      end else if (core_clk_en) begin
         run_cnt <= run_cnt + 32'h0000_0001;
      end
   end
endmodule : rcss_core_model

// ### testbench/reset_clock_startup_sequencer_tb.sv
// Self-checking testbench for the reset and clock start-up sequencer.
`timescale 1ns/100ps
`include "rcss_cfg.svh"
module reset_clock_startup_sequencer_tb import rcss_pkg::*;;
   // ============================================================
   // Stimulus and observation signals
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic brownout_det = 1'b0, osc_running = 1'b1, pll_lock = 1'b0;
   logic [2:0] cfg_osc_family_select = 3'h1;
   logic [4:0] cfg_primary_osc_mode_select = 5'h00;
   logic cfg_clock_fail_monitor_en = 1'b0, cfg_power_up_timer_en = 1'b0;
   logic cfg_brownout_en = 1'b1;
   logic [3:0] reg_addr = 4'h0;
   logic [15:0] reg_wdata = 16'h0000;
   logic reg_wr = 1'b0, reg_rd = 1'b0;
   logic [15:0] reg_rdata;
   logic core_rst, core_clk_en, pll_en, fast_rc_en, low_pwr_rc_en, clk_fail_trap;
   logic [1:0] clk_src_sel, pll_mult, pll_prediv;
   logic [3:0] fast_rc_trim_code;
   logic second_osc_pin_o, second_osc_pin_oe, second_osc_pin_gpio;
   logic [31:0] run_cnt;
   logic [15:0] rd;
   int error_cnt = 0, checks = 0, trap_seen = 0, n = 0;
   always #12.5 clk = ~clk;
   rcss_top #(.POWER_UP_TIMER_CYCLES(50), .OST_CYCLES(20)) rcss_top_i (.clk(clk), .rst(rst),
      .brownout_det(brownout_det), .osc_running(osc_running), .pll_lock(pll_lock),
      .cfg_osc_family_select(cfg_osc_family_select),
      .cfg_primary_osc_mode_select(cfg_primary_osc_mode_select),
      .cfg_clock_fail_monitor_en(cfg_clock_fail_monitor_en),
      .cfg_power_up_timer_en(cfg_power_up_timer_en), .cfg_brownout_en(cfg_brownout_en),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .core_rst(core_rst), .core_clk_en(core_clk_en),
      .clk_src_sel(clk_src_sel), .pll_en(pll_en), .pll_mult(pll_mult),
      .pll_prediv(pll_prediv), .fast_rc_trim_code(fast_rc_trim_code),
      .fast_rc_en(fast_rc_en), .low_pwr_rc_en(low_pwr_rc_en), .clk_fail_trap(clk_fail_trap),
      .second_osc_pin_o(second_osc_pin_o), .second_osc_pin_oe(second_osc_pin_oe),
      .second_osc_pin_gpio(second_osc_pin_gpio));
   rcss_core_model rcss_core_model_i (.clk(clk), .core_rst(core_rst),
      .core_clk_en(core_clk_en), .run_cnt(run_cnt));
   // ============================================================
   // Shared tasks
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task automatic reg_write(input logic [3:0] a, input logic [15:0] d);
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask : reg_write
   // Read data stand only in the cycle after the strobe, so sample just after that edge.
   task automatic reg_read(input logic [3:0] a, output logic [15:0] d);
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1;
      d = reg_rdata;
   endtask : reg_read
   // Configuration is only latched while the sequencer starts, so each change needs a reset.
   task automatic restart(input logic [2:0] f, input logic [4:0] m);
      @(posedge clk);
      rst <= 1'b1;
      cfg_osc_family_select <= f;
      cfg_primary_osc_mode_select <= m;
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      repeat (3) @(posedge clk);
      #1;
      trap_seen = 0;
   endtask : restart
   task automatic wait_run(input int lim);
      n = 0;
      while (core_rst !== 1'b0 && n < lim) begin
         @(posedge clk);
         #1;
         n++;
         if (clk_fail_trap === 1'b1) trap_seen++;
      end
   endtask : wait_run
   task automatic end_of_test;
      $display("checks %0d errors %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : end_of_test
   // ============================================================
   // Scenarios
   task automatic t_regs;
      restart(3'h1, 5'h00);
      reg_read(4'h0, rd);
      chk("trim reset", 16'h0000, rd);
      reg_read(4'h2, rd);
      chk("reset flags", 16'h0001, rd);
      reg_read(4'hf, rd);
      chk("unmapped", 16'h0000, rd);
      reg_write(4'h0, 16'hffff);
      reg_read(4'h0, rd);
      chk("trim width", 16'h000f, rd);
      reg_write(4'h0, 16'h0008);
      #1;
      chk("trim code", 16'h0008, {12'h000, fast_rc_trim_code});
      $display("test regs done");
   endtask : t_regs
   task automatic t_rc(input logic [2:0] f, input logic [1:0] src);
      restart(f, 5'h00);
      wait_run(600);
      chk("por delay", 16'h0001, {15'h0000, n >= 390 && n <= 410});
      chk("clk ready", 16'h0001, {15'h0000, core_clk_en});
      chk("src", {14'h0000, src}, {14'h0000, clk_src_sel});
      chk("rc en", {14'h0000, src == 2'h1, src == 2'h0},
         {14'h0000, low_pwr_rc_en, fast_rc_en});
      $display("test rc source done");
   endtask : t_rc
   task automatic t_pll;
      logic [4:0] md [8] = '{5'h01, 5'h02, 5'h03, 5'h09, 5'h0f, 5'h16, 5'h1f, 5'h04};
      logic [4:0] ex [8] = '{5'h14, 5'h18, 5'h1c, 5'h15, 5'h1e, 5'h18, 5'h1c, 5'h00};
      // Every mode here keeps the PLL output inside the maximum core frequency.
      for (int i = 0; i < 8; i++) begin
         restart(3'h0, md[i]);
         chk("pll cfg", {11'h000, ex[i]}, {11'h000, pll_en, pll_mult, pll_prediv});
      end
      $display("test pll modes done");
   endtask : t_pll
   task automatic t_lock;
      @(posedge clk);
      osc_running <= 1'b0;
      pll_lock <= 1'b0;
      restart(3'h0, 5'h01);
      wait_run(5000);
      chk("monitor delay", 16'h0001, {15'h0000, n >= 3990 && n <= 4450});
      chk("frozen core", 16'h0000, run_cnt[15:0]);
      chk("no trap", 16'h0000, trap_seen[15:0]);
      @(posedge clk);
      osc_running <= 1'b1;
      repeat (12) @(posedge clk);
      #1;
      chk("ost hold", 16'h0000, {15'h0000, core_clk_en});
      repeat (30) @(posedge clk);
      #1;
      chk("lock hold", 16'h0000, {15'h0000, core_clk_en});
      @(posedge clk);
      pll_lock <= 1'b1;
      repeat (10) @(posedge clk);
      #1;
      chk("clk ready", 16'h0001, {15'h0000, core_clk_en});
      chk("core runs", 16'h0001, {15'h0000, run_cnt != 32'h0000_0000});
      $display("test lock done");
   endtask : t_lock
   task automatic t_brownout;
      reg_write(4'h2, 16'h0000);
      reg_write(4'h0, 16'h0005);
      @(posedge clk);
      brownout_det <= 1'b1;
      repeat (8) @(posedge clk);
      #1;
      chk("bor reset", 16'h0001, {15'h0000, core_rst});
      @(posedge clk);
      brownout_det <= 1'b0;
      repeat (8) @(posedge clk);
      #1;
      chk("bor trim", 16'h0000, {12'h000, fast_rc_trim_code});
      reg_read(4'h2, rd);
      chk("bor flag", 16'h0002, rd);
      wait_run(5000);
      chk("bor delay", 16'h0001, {15'h0000, n >= 3980 && n <= 4450});
      chk("bor src", {14'h0000, SRC_PRIMARY}, {14'h0000, clk_src_sel});
      chk("bor pll", 16'h0001, {15'h0000, pll_en});
      $display("test brownout done");
   endtask : t_brownout
   task automatic t_pin;
      logic [7:0] p;
      restart(3'h0, 5'h18);
      for (int i = 0; i < 8; i++) begin
         @(posedge clk);
         #1;
         p[i] = second_osc_pin_o;
      end
      chk("pin drive", 16'h0002, {14'h0000, second_osc_pin_oe, second_osc_pin_gpio});
      chk("quarter clk", 16'h0001, {15'h0000, p[7:4] == p[3:0] && p[0] != p[2]
         && p[1] != p[3] && $countones(p) == 4});
      restart(3'h0, 5'h14);
      chk("ext clk io", 16'h0001, {14'h0000, second_osc_pin_oe, second_osc_pin_gpio});
      restart(3'h0, 5'h19);
      chk("ext rc io", 16'h0001, {14'h0000, second_osc_pin_oe, second_osc_pin_gpio});
      $display("test second pin done");
   endtask : t_pin
   task automatic t_fail;
      @(posedge clk);
      cfg_clock_fail_monitor_en <= 1'b1;
      osc_running <= 1'b0;
      restart(3'h0, 5'h10);
      wait_run(600);
      chk("no early trap", 16'h0000, trap_seen[15:0]);
      for (int i = 0; i < 10 && trap_seen == 0; i++) begin
         @(posedge clk);
         #1;
         if (clk_fail_trap === 1'b1) trap_seen++;
      end
      chk("trap", 16'h0001, trap_seen[15:0]);
      @(posedge clk);
      #1;
      chk("trap pulse", 16'h0000, {15'h0000, clk_fail_trap});
      chk("fallback", 16'h0001, {13'h0000, clk_src_sel, core_clk_en});
      reg_read(4'h1, rd);
      chk("fail bit", 16'h0008, rd & 16'h0008);
      @(posedge clk);
      osc_running <= 1'b1;
      reg_write(4'h1, 16'h0080);
      repeat (12) @(posedge clk);
      #1;
      chk("switch back", {14'h0000, SRC_PRIMARY}, {14'h0000, clk_src_sel});
      reg_read(4'h1, rd);
      chk("fail clear", 16'h0000, rd & 16'h0008);
      $display("test clock fail done");
   endtask : t_fail
   // ============================================================
   // Main sequence and watchdog
   initial begin
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      t_regs();
      t_rc(3'h1, 2'h0);
      t_rc(3'h2, 2'h1);
      t_pll();
      t_lock();
      t_brownout();
      t_pin();
      t_fail();
      end_of_test();
   end
   initial begin
      repeat (40000) @(posedge clk);
      error_cnt++;
      end_of_test();
   end
endmodule : reset_clock_startup_sequencer_tb
